/* pingpong_pkg.sv */
// Shared constants and carrier types for the ping-pong tape record buffer
package pingpong_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned HS_TIMEOUT_MS      = 6;          // Byte handshake limit in ms
  localparam int unsigned HS_TIMEOUT_CYCLES  = HS_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned XFER_RATE_BPS      = 86_000;     // Tape transfer rate, bytes/s
  localparam int unsigned PACE_CYCLES        = CLK_HZ / XFER_RATE_BPS;
  localparam logic [16:0] HS_TIMEOUT_CYC     = 17'(HS_TIMEOUT_CYCLES);
  localparam logic [7:0]  PACE_CYC           = 8'(PACE_CYCLES);

  // Buffer geometry
  localparam logic [11:0] BUF_DEPTH          = 12'hE00;    // 3584 characters per buffer
  localparam logic [11:0] BUF_LAST           = 12'hDFF;    // Index of last character
  localparam logic [8:0]  BLOCK_LAST         = 9'h1FF;     // Last byte of a 512-byte block
  localparam int unsigned FIFO_DEPTH         = 8;

  // Commands sent to the tape drive
  localparam logic [7:0]  CMD_WRITE          = 8'h01;
  localparam logic [7:0]  CMD_WRITE_MARK     = 8'h02;
  localparam logic [7:0]  CMD_READ_STATUS    = 8'h03;

  // Status byte 0 and 1 bit positions
  localparam int unsigned ST0_NO_CART_BIT    = 6;
  localparam int unsigned ST0_WR_PROT_BIT    = 4;
  localparam int unsigned ST0_DATA_ERR_BIT   = 3;
  localparam int unsigned ST0_END_TAPE_BIT   = 2;
  localparam int unsigned ST1_FATAL_BIT      = 0;

  // Command strobe with its code
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } tape_cmd_t;

  // One byte on its way to the drive
  typedef struct packed {
    logic       block_end;
    logic [7:0] data;
  } tape_byte_t;

  // Front-panel lamps
  typedef struct packed {
    logic no_cartridge;
    logic write_protect;
    logic data_error;
    logic end_of_tape;
    logic fatal;
  } lamps_t;

  // Flat address of a character in the two-buffer memory
  function automatic logic [12:0] buf_addr(input logic sel, input logic [11:0] idx);
    buf_addr = 13'(sel ? BUF_DEPTH : 12'h000) + {1'b0, idx};
  endfunction : buf_addr

endpackage : pingpong_pkg

/* byte_fifo.sv */
// Small valid/ready FIFO between buffer readout and the drive handshake
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t r_ff;
  fifo_state_t nxt_r;
  logic        push;
  logic        pop;

  // Honest full and empty
  assign in_ready_o  = (r_ff.count != (AW+1)'(DEPTH));
  assign out_valid_o = (r_ff.count != '0);
  assign out_data_o  = r_ff.mem[r_ff.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb
  begin
    nxt_r = r_ff;
    if (push)
    begin
      nxt_r.mem[r_ff.wr_ptr] = in_data_i;
      nxt_r.wr_ptr           = AW'(r_ff.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      nxt_r.rd_ptr = AW'(r_ff.rd_ptr + 1'b1);
    end
    nxt_r.count = (AW+1)'(r_ff.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (flush_i)
    begin
      nxt_r.wr_ptr = '0;
      nxt_r.rd_ptr = '0;
      nxt_r.count  = '0;
    end
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end
endmodule : byte_fifo
`default_nettype wire

/* tape_status_decode.sv */
// Captures drive status bytes 0 and 1 and drives the five panel lamps
`timescale 1ns/1ps
`default_nettype none
module tape_status_decode
  import pingpong_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       byte_valid_i,
  input  wire logic       byte_index_i,
  input  wire logic [7:0] byte_i,
  output lamps_t          lamps_o
);
  typedef struct packed {
    logic [7:0] status0;
    lamps_t     lamps;
  } dec_state_t;

  dec_state_t r_ff;
  dec_state_t nxt_r;

  // Byte 0 is held; lamps update together once byte 1 arrives
  always_comb
  begin
    nxt_r = r_ff;
    if (byte_valid_i && !byte_index_i)
    begin
      nxt_r.status0 = byte_i;
    end
    if (byte_valid_i && byte_index_i)
    begin
      nxt_r.lamps.no_cartridge  = r_ff.status0[ST0_NO_CART_BIT];
      nxt_r.lamps.write_protect = r_ff.status0[ST0_WR_PROT_BIT];
      nxt_r.lamps.data_error    = r_ff.status0[ST0_DATA_ERR_BIT];
      nxt_r.lamps.end_of_tape   = r_ff.status0[ST0_END_TAPE_BIT];
      nxt_r.lamps.fatal         = byte_i[ST1_FATAL_BIT];
    end
  end

  // Lamp register
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign lamps_o = r_ff.lamps;
endmodule : tape_status_decode
`default_nettype wire

/* pingpong_tape_record_buffer.sv */
// Ping-pong character buffer feeding a streaming tape drive
`timescale 1ns/1ps
`default_nettype none
module pingpong_tape_record_buffer
  import pingpong_pkg::*;
#(
  parameter logic [16:0] HS_TIMEOUT = HS_TIMEOUT_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output tape_cmd_t       cmd_o,
  input  wire logic       cmd_ack_i,
  output logic            tape_req_o,
  input  wire logic       tape_ack_i,
  output logic [7:0]      tape_data_o,
  output logic            tape_block_end_o,
  input  wire logic       tape_done_i,
  input  wire logic       status_valid_i,
  input  wire logic [7:0] status_data_i,
  output lamps_t          lamps_o,
  output logic            input_sel_o,
  output logic            busy_o,
  output logic            overrun_o,
  output logic            timeout_o
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD_WRITE,
    S_XFER,
    S_DRAIN,
    S_CMD_MARK,
    S_MARK_WAIT,
    S_CMD_STATUS,
    S_STATUS
  } seq_state_t;

  typedef struct packed {
    seq_state_t       st;
    logic             in_sel;
    logic [1:0]       full;
    logic [1:0][11:0] cnt;
    logic             tx_sel;
    logic [11:0]      rd_idx;
    logic [7:0]       pace;
    tape_cmd_t        cmd;
    logic [16:0]      wait_cnt;
    logic             stat_idx;
    logic             overrun;
    logic             timeout;
  } ctrl_state_t;

  ctrl_state_t r_ff;
  ctrl_state_t nxt_r;

  // Sequencer states in which bytes are in flight towards the drive
  function automatic logic sending(input seq_state_t st);
    sending = (st == S_XFER) || (st == S_DRAIN);
  endfunction : sending

  // Command strobe raised with the given code
  function automatic tape_cmd_t issue(input logic [7:0] op);
    issue = '{valid: 1'b1, code: op};
  endfunction : issue

  // Next character index within one buffer
  function automatic logic [11:0] step_idx(input logic [11:0] idx);
    step_idx = 12'(idx + 1'b1);
  endfunction : step_idx

  // Both character buffers in one array, buffer 1 starting BUF_DEPTH entries above buffer 0
  logic [7:0] buf_mem [0:(2*BUF_DEPTH)-1];

  logic       fifo_in_valid;
  logic       fifo_in_ready;
  tape_byte_t fifo_in_data;
  logic       fifo_out_valid;
  tape_byte_t fifo_out_data;
  logic       fifo_flush;
  logic       stat_byte_valid;
  logic       fill_last;
  logic       byte_taken;
  logic       hs_expired;

  // Character store into the selected input buffer
  always_ff @(posedge clock_i)
  begin
    if (rx_valid_i)
    begin
      buf_mem[buf_addr(r_ff.in_sel, r_ff.cnt[r_ff.in_sel])] <= rx_data_i;
    end
  end

  // Readout of the buffer being sent, paced towards the FIFO
  assign fifo_in_data.data      = buf_mem[buf_addr(r_ff.tx_sel, r_ff.rd_idx)];
  assign fifo_in_data.block_end = (r_ff.rd_idx[8:0] == BLOCK_LAST);
  assign fifo_in_valid          = (r_ff.st == S_XFER) && (r_ff.pace == 8'h00);
  assign fill_last              = (r_ff.cnt[r_ff.in_sel] == BUF_LAST);
  assign stat_byte_valid        = (r_ff.st == S_STATUS) && status_valid_i;
  assign byte_taken             = fifo_in_valid && fifo_in_ready;

  // Watchdog expiry on a byte the drive has not taken
  assign hs_expired = sending(r_ff.st) && (r_ff.wait_cnt == 17'(HS_TIMEOUT - 1'b1));

  // Next-state logic for input side and tape sequencer
  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.overrun = 1'b0;
    fifo_flush    = 1'b0;

    // Input side: fill, switch or overwrite
    if (rx_valid_i)
    begin
      if (!fill_last)
      begin
        nxt_r.cnt[r_ff.in_sel] = step_idx(r_ff.cnt[r_ff.in_sel]);
      end
      else if (!r_ff.full[!r_ff.in_sel])
      begin
        nxt_r.full[r_ff.in_sel] = 1'b1;
        nxt_r.in_sel            = !r_ff.in_sel;
        nxt_r.cnt[!r_ff.in_sel] = 12'h000;
      end
      else
      begin
        nxt_r.cnt[r_ff.in_sel] = 12'h000;
        nxt_r.overrun          = 1'b1;
      end
    end

    // Pacing counter between buffer reads
    if (r_ff.st == S_XFER)
    begin
      if (byte_taken)
      begin
        nxt_r.pace = 8'(PACE_CYC - 1'b1);
      end
      else if (r_ff.pace != 8'h00)
      begin
        nxt_r.pace = 8'(r_ff.pace - 1'b1);
      end
    end

    // Per-byte handshake watchdog
    if (sending(r_ff.st))
    begin
      if (!fifo_out_valid || tape_ack_i)
      begin
        nxt_r.wait_cnt = 17'h00000;
      end
      else
      begin
        nxt_r.wait_cnt = 17'(r_ff.wait_cnt + 1'b1);
      end
    end
    else
    begin
      nxt_r.wait_cnt = 17'h00000;
    end

    // Tape sequencer
    unique case (r_ff.st)
      // Wait for the other buffer to fill, then open a write
      S_IDLE:
      begin
        if (r_ff.full[!r_ff.in_sel])
        begin
          nxt_r.tx_sel   = !r_ff.in_sel;
          nxt_r.rd_idx   = 12'h000;
          nxt_r.pace     = 8'h00;
          nxt_r.timeout  = 1'b0;
          nxt_r.cmd      = issue(CMD_WRITE);
          nxt_r.st       = S_CMD_WRITE;
        end
      end

      // Hold the write command until the drive takes it
      S_CMD_WRITE:
      begin
        if (cmd_ack_i)
        begin
          nxt_r.cmd.valid = 1'b0;
          nxt_r.st        = S_XFER;
        end
      end

      // Feed the buffer into the byte queue, one byte per pace interval
      S_XFER:
      begin
        if (byte_taken)
        begin
          if (r_ff.rd_idx == BUF_LAST)
          begin
            nxt_r.st = S_DRAIN;
          end
          else
          begin
            nxt_r.rd_idx = step_idx(r_ff.rd_idx);
          end
        end
      end

      // Let the queue empty, then ask for the file mark
      S_DRAIN:
      begin
        if (!fifo_out_valid)
        begin
          nxt_r.cmd = issue(CMD_WRITE_MARK);
          nxt_r.st  = S_CMD_MARK;
        end
      end

      // Hold the file mark command until the drive takes it
      S_CMD_MARK:
      begin
        if (cmd_ack_i)
        begin
          nxt_r.cmd.valid = 1'b0;
          nxt_r.st        = S_MARK_WAIT;
        end
      end

      // Mark written; fetch status before the buffer is released
      S_MARK_WAIT:
      begin
        if (tape_done_i)
        begin
          nxt_r.cmd = issue(CMD_READ_STATUS);
          nxt_r.st  = S_CMD_STATUS;
        end
      end

      // Hold the status request until the drive takes it
      S_CMD_STATUS:
      begin
        if (cmd_ack_i)
        begin
          nxt_r.cmd.valid = 1'b0;
          nxt_r.stat_idx  = 1'b0;
          nxt_r.st        = S_STATUS;
        end
      end

      // Two status bytes; the second one frees the sent buffer
      S_STATUS:
      begin
        if (status_valid_i)
        begin
          nxt_r.stat_idx = 1'b1;
          if (r_ff.stat_idx)
          begin
            nxt_r.full[r_ff.tx_sel] = 1'b0;
            nxt_r.st                = S_IDLE;
          end
        end
      end
    endcase

    // Handshake overrun aborts the transfer and fetches status
    if (hs_expired)
    begin
      nxt_r.timeout = 1'b1;
      nxt_r.cmd     = issue(CMD_READ_STATUS);
      nxt_r.st      = S_CMD_STATUS;
      fifo_flush    = 1'b1;
    end
  end

  // Control state register
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      r_ff    <= '0;
      r_ff.st <= S_IDLE;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Byte buffer towards the drive handshake
  byte_fifo #(
    .WIDTH ($bits(tape_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .flush_i     (fifo_flush),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tape_ack_i),
    .out_data_o  (fifo_out_data)
  );

  // Status capture and lamp decode
  tape_status_decode u_status (
    .clock_i      (clock_i),
    .resetn_i     (resetn_i),
    .byte_valid_i (stat_byte_valid),
    .byte_index_i (r_ff.stat_idx),
    .byte_i       (status_data_i),
    .lamps_o      (lamps_o)
  );

  // Outputs
  assign cmd_o            = r_ff.cmd;
  assign tape_req_o       = fifo_out_valid;
  assign tape_data_o      = fifo_out_data.data;
  assign tape_block_end_o = fifo_out_data.block_end;
  assign input_sel_o      = r_ff.in_sel;
  assign busy_o           = (r_ff.st != S_IDLE);
  assign overrun_o        = r_ff.overrun;
  assign timeout_o        = r_ff.timeout;

endmodule : pingpong_tape_record_buffer
`default_nettype wire

/* pingpong_tape_record_buffer_properties.sv */
// Port checker for the ping-pong tape buffer
`timescale 1ns/1ps
`default_nettype none
module pingpong_checker
  import pingpong_pkg::*;
#(
  parameter logic [16:0] HS_TIMEOUT = HS_TIMEOUT_CYC
) (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire tape_cmd_t  cmd_o,
  input wire logic       cmd_ack_i,
  input wire logic       tape_req_o,
  input wire logic       tape_ack_i,
  input wire logic [7:0] tape_data_o,
  input wire logic       tape_block_end_o,
  input wire logic       tape_done_i,
  input wire logic       status_valid_i,
  input wire logic [7:0] status_data_i,
  input wire lamps_t     lamps_o,
  input wire logic       input_sel_o,
  input wire logic       busy_o,
  input wire logic       overrun_o,
  input wire logic       timeout_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  logic [17:0] wait_ff;
  logic [11:0] pop_ff;

  // Stalled handshake cycles, and bytes taken since the write command
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i || !tape_req_o || tape_ack_i)
      wait_ff <= '0;
    else
      wait_ff <= wait_ff + 18'h1;
    if (!resetn_i || (cmd_o.valid && cmd_ack_i && cmd_o.code == CMD_WRITE))
      pop_ff <= '0;
    else if (tape_req_o && tape_ack_i)
      pop_ff <= pop_ff + 12'h1;
  end

  a_reset_idle: assert property ($rose(resetn_i) |-> !cmd_o.valid && !busy_o
    && !input_sel_o && !tape_req_o && lamps_o == '0) else $error("not idle after reset");
  a_cmd_hold: assert property (cmd_o.valid && !cmd_ack_i |=> $stable(cmd_o))
    else $error("command moved before ack");
  a_sel_cause: assert property ($changed(input_sel_o) |-> $past(rx_valid_i))
    else $error("buffer switch without char");
  a_write_first: assert property ($rose(busy_o) |-> ##[0:2]
    (cmd_o.valid && cmd_o.code == CMD_WRITE)) else $error("no write command");
  a_timeout_status: assert property ($rose(timeout_o) |-> ##[0:3]
    (cmd_o.valid && cmd_o.code == CMD_READ_STATUS)) else $error("no status read");
  a_lamp_cause: assert property ($changed(lamps_o) |->
    $past(status_valid_i) || $past(status_valid_i, 2)) else $error("lamps moved alone");
  a_block_end: assert property (tape_req_o |->
    tape_block_end_o == (pop_ff[8:0] == BLOCK_LAST)) else $error("block end misplaced");
  a_hs_bound: assert property (wait_ff <= {1'b0, HS_TIMEOUT} + 18'h2)
    else $error("handshake wait too long");
endmodule : pingpong_checker

bind pingpong_tape_record_buffer pingpong_checker #(.HS_TIMEOUT(HS_TIMEOUT)) chk (
  .clock_i, .resetn_i, .rx_valid_i, .rx_data_i, .cmd_o, .cmd_ack_i,
  .tape_req_o, .tape_ack_i, .tape_data_o, .tape_block_end_o, .tape_done_i,
  .status_valid_i, .status_data_i, .lamps_o, .input_sel_o, .busy_o,
  .overrun_o, .timeout_o
);
`default_nettype wire

/* tape_drive_model.sv */
// Behavioural tape drive answering commands, bytes and status reads
`timescale 1ns/1ps
`default_nettype none
module tape_drive_model
  import pingpong_pkg::*;
(
  input  wire logic       clock_i,
  input  wire tape_cmd_t  cmd_i,
  output logic            cmd_ack_o,
  input  wire logic       req_i,
  output logic            ack_o,
  input  wire logic [7:0] data_i,
  output logic            done_o,
  output logic            st_valid_o,
  output logic [7:0]      st_data_o
);
  logic [7:0] rx_q[$];
  logic [7:0] code_q[$];
  logic [7:0] st0 = 8'h00;
  logic [7:0] st1 = 8'h00;
  bit         ack_en = 1'b0;
  bit         st_go = 1'b1;
  int         ack_dly = 0;
  int         wt = 0;
  int         mark_n = 0;
  int         st_n = 0;

  // Accepted bytes pile up in the drive's own buffer, and command codes in a second queue
  always @(posedge clock_i)
  begin
    if (req_i && ack_o)
      rx_q.push_back(data_i);
    if (cmd_i.valid && cmd_ack_o)
      code_q.push_back(cmd_i.code);
  end

  // Answer commands, pace byte acks and play back status bytes
  initial
  begin
    {cmd_ack_o, ack_o, done_o, st_valid_o} = 4'h0;
    st_data_o = 8'h00;
    forever
    begin
      @(posedge clock_i);
      #2;
      if (cmd_ack_o && code_q[$] == CMD_WRITE_MARK)
        mark_n = 4;
      if (cmd_ack_o && code_q[$] == CMD_READ_STATUS)
        st_n = 1;
      cmd_ack_o = cmd_i.valid;
      done_o = (mark_n == 1);
      mark_n = (mark_n > 0) ? mark_n - 1 : 0;
      st_valid_o = 1'b0;
      st_data_o = ~st_data_o;
      if (st_n > 0 && st_go)
        st_n++;
      if (st_n == 3 || st_n == 5)
      begin
        st_valid_o = 1'b1;
        st_data_o = (st_n == 3) ? st0 : st1;
      end
      if (st_n == 5)
        st_n = 0;
      ack_o = 1'b0;
      wt = (req_i && ack_en) ? wt + 1 : 0;
      if (wt > ack_dly)
      begin
        ack_o = 1'b1;
        wt = 0;
      end
    end
  end
endmodule : tape_drive_model
`default_nettype wire

/* pingpong_tape_record_buffer_tb.sv */
// Self-checking bench for the ping-pong tape record buffer
`timescale 1ns/1ps
`default_nettype none
module pingpong_tape_record_buffer_tb;
  import pingpong_pkg::*;
  localparam int LIMIT = 30000;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  tape_cmd_t  cmd_o;
  logic       cmd_ack_i, tape_req_o, tape_ack_i, tape_block_end_o, tape_done_i;
  logic       status_valid_i, input_sel_o, busy_o, overrun_o, timeout_o;
  logic [7:0] tape_data_o, status_data_i;
  lamps_t     lamps_o;
  int         bad_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         nchar = 0;
  int         ov_n = 0;
  int         w;

  pingpong_tape_record_buffer #(.HS_TIMEOUT(17'h00032)) DUT (
    .clock_i, .resetn_i, .rx_valid_i, .rx_data_i, .cmd_o, .cmd_ack_i,
    .tape_req_o, .tape_ack_i, .tape_data_o, .tape_block_end_o, .tape_done_i,
    .status_valid_i, .status_data_i, .lamps_o, .input_sel_o, .busy_o,
    .overrun_o, .timeout_o
  );

  tape_drive_model DRV (
    .clock_i, .cmd_i(cmd_o), .cmd_ack_o(cmd_ack_i), .req_i(tape_req_o),
    .ack_o(tape_ack_i), .data_i(tape_data_o), .done_o(tape_done_i),
    .st_valid_o(status_valid_i), .st_data_o(status_data_i)
  );

  always #25 clock_i = ~clock_i;

  // Cycle ceiling and overrun pulse counter
  always @(posedge clock_i)
  begin
    cyc++;
    if (overrun_o === 1'b1)
      ov_n++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 5 + 3);
  endfunction : pat

  // One clock, then past the edge's updates
  task automatic tick();
    @(posedge clock_i);
    #2;
  endtask : tick

  task automatic await(ref logic s, input logic v, input int n);
    int i;
    for (i = 0; i < n && s !== v; i++)
      tick();
  endtask : await

  // One character source feeds the receiver, back to back
  task automatic fill(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      #2;
      rx_valid_i = 1'b1;
      rx_data_i = pat(nchar);
      nchar++;
    end
    @(posedge clock_i);
    #2;
    rx_valid_i = 1'b0;
  endtask : fill

  task automatic s_reset();
    chk("cmd", 8'h00, {7'h00, cmd_o.valid});
    chk("flags", 8'h00, {3'h0, busy_o, input_sel_o, tape_req_o, overrun_o, timeout_o});
    chk("lamps", 8'h00, {3'h0, lamps_o});
  endtask : s_reset

  // Buffer 0 fills to the last slot and hands over
  task automatic s_fill0();
    fill(3583);
    chk("sel", 8'h00, {7'h00, input_sel_o});
    fill(1);
    chk("sel", 8'h01, {7'h00, input_sel_o});
    await(busy_o, 1'b1, 20);
    chk("req", 8'h00, {7'h00, tape_req_o});
    for (w = 0; w < 20 && DRV.code_q.size() < 1; w++)
      tick();
    chk("cmd", CMD_WRITE, DRV.code_q[0]);
  endtask : s_fill0

  // Buffer 0 streams out while buffer 1 fills, then the drive stalls
  task automatic s_stream();
    int t;
    DRV.ack_en = 1'b1;
    fill(100);
    for (w = 0; w < 2000 && DRV.rx_q.size() < 3; w++)
      tick();
    t = cyc;
    for (w = 0; w < 400 && DRV.rx_q.size() < 4; w++)
      tick();
    chk("pace", PACE_CYC, 8'(cyc - t));
    for (w = 0; w < 4; w++)
      chk("byte", pat(w), DRV.rx_q[w]);
    DRV.st0 = 8'h5C;
    DRV.st1 = 8'h01;
    DRV.ack_en = 1'b0;
    await(timeout_o, 1'b1, 800);
    chk("tmo", 8'h01, {7'h00, timeout_o});
    await(busy_o, 1'b0, 200);
    chk("stat", CMD_READ_STATUS, DRV.code_q[1]);
    chk("lamps", 8'h1F, {3'h0, lamps_o});
  endtask : s_stream

  // Buffer 1 completes, leaves slowly, and its status read is held
  task automatic s_fill1();
    fill(3484);
    chk("sel", 8'h00, {7'h00, input_sel_o});
    await(busy_o, 1'b1, 20);
    DRV.rx_q.delete();
    DRV.ack_dly = 4;
    DRV.ack_en = 1'b1;
    for (w = 0; w < 2000 && DRV.rx_q.size() < 2; w++)
      tick();
    chk("tmo", 8'h00, {7'h00, timeout_o});
    chk("byte", pat(3584), DRV.rx_q[0]);
    chk("byte", pat(3585), DRV.rx_q[1]);
    DRV.st_go = 1'b0;
    DRV.st0 = 8'h40;
    DRV.st1 = 8'h00;
    DRV.ack_en = 1'b0;
    await(tape_req_o, 1'b1, 400);
    chk("req", 8'h01, {7'h00, tape_req_o});
    chk("bend", 8'h00, {7'h00, tape_block_end_o});
    await(timeout_o, 1'b1, 800);
    chk("tmo", 8'h01, {7'h00, timeout_o});
  endtask : s_fill1

  // Buffer 0 fills again while buffer 1 is still held
  task automatic s_overrun();
    fill(3584);
    repeat (2)
      @(posedge clock_i);
    chk("ovr", 8'h01, 8'(ov_n));
    chk("sel", 8'h00, {7'h00, input_sel_o});
    DRV.st_go = 1'b1;
    await(busy_o, 1'b0, 200);
    chk("lamps", 8'h10, {3'h0, lamps_o});
  endtask : s_overrun

  // Reset, then run the scenarios in order
  initial
  begin
    repeat (12)
      @(posedge clock_i);
    #2;
    s_reset();
    resetn_i = 1'b1;
    s_fill0();
    s_stream();
    s_fill1();
    s_overrun();
    final_report();
  end
endmodule : pingpong_tape_record_buffer_tb
`default_nettype wire
